// ==== src/sfr_top.sv ====
// serial frame parser: apb registers, armed receive slots, delayed transmit
// How it works
// - skip field drops a set count of bytes, 1 to 249, before parsing
// - first leading constant byte is start marker, last trailing byte end marker
// - markers limited to 00h-7Fh for 7-bit characters, 00h-FFh for 8-bit
// - any variable-length storage field makes the whole command variable-length
// - no markers, variable: take up to max length, end on character timeout
// - no markers, fixed: receive from first byte, end at exact command length
// - several armed commands with both markers all parse the same bytes
// - armed command missing a marker owns the data; highest index wins
// - start marker never seen: bytes silently dropped, no error raised
// - after start marker, reception completes at max count without end marker
// - crc mode compares raw two-byte result, low byte first, with check field
// - receive command armed while its trigger flag stays at 1
// - transmit command starts on trigger flag rising 0 to 1
// - transmit waits programmed delay in 100 ms units before first byte
// - successful completion sets that command's completion flag
// - error-free completion leaves status word 0 all zero
// - check mismatch sets bit 0 of status word 0
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "sfr_regs.svh"
module sfr_top #(
    parameter int unsigned TICK_CYCLES = `SFR_CLK_HZ / 1000 * `SFR_TICK_MS
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire sfr_pkg::sfr_apb_req_t apb_req,
    output sfr_pkg::sfr_apb_rsp_t apb_rsp,
    input wire sfr_pkg::sfr_byte_t rx_byte,
    output sfr_pkg::sfr_byte_t tx_byte,
    input wire logic tx_ready,
    output logic irq
);
    localparam int SLOTS = sfr_pkg::SFR_SLOTS;

    sfr_pkg::sfr_state_t q;
    sfr_pkg::sfr_state_t d;
    logic tick;
    logic setup;
    logic access;
    logic wr;
    logic hit;
    logic any_open;
    logic to_ev;
    logic tx_rise;
    logic fin;
    logic bad;
    logic [31:0] rdv;
    logic [31:0] w;
    logic [7:0] soff;
    logic [7:0] bval;
    logic [7:0] wcode;
    logic [3:0] win;
    logic [SLOTS-1:0] sel;
    logic [7:0] ncnt;
    logic [7:0] nnew;
    logic [7:0] nold;
    logic [15:0] ncrc;

    sfr_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ `SFR_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_upd

    function automatic logic [31:0] pack_stat(input logic [SLOTS-1:0] dn,
                                              input logic [SLOTS-1:0] er, input logic td);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[`SFR_IS_DONE_LSB +: SLOTS] = dn;
        r[`SFR_IS_ERR_LSB +: SLOTS] = er;
        r[`SFR_IS_TX_BIT] = td;
        return r;
    endfunction : pack_stat

    // markers stored already narrowed, so compares need no mode check
    function automatic logic [7:0] narrow(input logic [7:0] v, input logic c8);
        return c8 ? v : {1'b0, v[6:0]};
    endfunction : narrow

    always_comb begin
        d = q;
        w = apb_req.pwdata;
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && q.rsp.pready;
        wr = access && apb_req.pwrite;
        soff = apb_req.paddr - `SFR_SLOT_BASE;
        rdv = 32'h0000_0000;
        hit = 1'b1;
        wcode = 8'h00;
        fin = 1'b0;
        bad = 1'b0;
        ncnt = 8'h00;
        nnew = 8'h00;
        nold = 8'h00;
        ncrc = 16'h0000;
        bval = narrow(rx_byte.data, q.char8);

        // read decode, answered one cycle after setup
        case (apb_req.paddr)
            `SFR_ADDR_CFG: begin
                rdv[`SFR_CFG_CHAR8_BIT] = q.char8;
                rdv[`SFR_CFG_TO_LSB +: 8] = q.timeout;
            end
            `SFR_ADDR_RXARM: rdv[SLOTS-1:0] = q.arm;
            `SFR_ADDR_TXCTRL: begin
                rdv[`SFR_TX_TRIG_BIT] = q.tx_trig;
                rdv[`SFR_TX_DELAY_LSB +: 8] = q.tx_delay;
                rdv[`SFR_TX_LEN_LSB +: 2] = q.tx_len;
                rdv[`SFR_TX_BUSY_BIT] = q.txst != sfr_pkg::TX_IDLE;
            end
            `SFR_ADDR_TXDATA: rdv = q.tx_data;
            `SFR_ADDR_ISTAT: rdv = pack_stat(q.rx_done, q.rx_err, q.tx_done);
            `SFR_ADDR_IMASK: rdv = q.mask;
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < SLOTS; i++) begin
            if (apb_req.paddr >= `SFR_SLOT_BASE && soff[7:4] == 4'(i)) begin
                hit = 1'b1;
                case (soff[3:0])
                    `SFR_SLOT_CFG0: begin
                        rdv[`SFR_C0_START_LSB +: 8] = q.cfg[i].start_code;
                        rdv[`SFR_C0_END_LSB +: 8] = q.cfg[i].end_code;
                        rdv[`SFR_C0_SEN_BIT] = q.cfg[i].start_en;
                        rdv[`SFR_C0_EEN_BIT] = q.cfg[i].end_en;
                        rdv[`SFR_C0_VAR_BIT] = q.cfg[i].variable;
                        rdv[`SFR_C0_CRC_BIT] = q.cfg[i].crc_en;
                    end
                    `SFR_SLOT_CFG1: begin
                        rdv[`SFR_C1_SKIP_LSB +: 8] = q.cfg[i].skip;
                        rdv[`SFR_C1_LEN_LSB +: 8] = q.cfg[i].len;
                    end
                    `SFR_SLOT_STAT: rdv[`SFR_ST_CHKERR_BIT] = q.slot[i].chk_err;
                    default: hit = 1'b0;
                endcase
            end
        end
        d.rsp.pready = setup;
        d.rsp.pslverr = setup && !hit;
        d.rsp.prdata = setup ? rdv : 32'h0000_0000;

        // writes first, so hardware sets further down win over clears
        if (wr) begin
            case (apb_req.paddr)
                `SFR_ADDR_CFG: begin
                    d.char8 = w[`SFR_CFG_CHAR8_BIT];
                    d.timeout = w[`SFR_CFG_TO_LSB +: 8];
                end
                `SFR_ADDR_RXARM: d.arm = w[SLOTS-1:0];
                `SFR_ADDR_TXCTRL: begin
                    d.tx_trig = w[`SFR_TX_TRIG_BIT];
                    d.tx_delay = w[`SFR_TX_DELAY_LSB +: 8];
                    d.tx_len = w[`SFR_TX_LEN_LSB +: 2];
                end
                `SFR_ADDR_TXDATA: d.tx_data = w;
                `SFR_ADDR_ISTAT: begin
                    d.rx_done = q.rx_done & ~w[`SFR_IS_DONE_LSB +: SLOTS];
                    d.rx_err = q.rx_err & ~w[`SFR_IS_ERR_LSB +: SLOTS];
                    d.tx_done = q.tx_done & ~w[`SFR_IS_TX_BIT];
                end
                `SFR_ADDR_IMASK: d.mask = w & pack_stat('1, '1, 1'b1);
                default: d.mask = d.mask;
            endcase
            for (int i = 0; i < SLOTS; i++) begin
                if (apb_req.paddr >= `SFR_SLOT_BASE && soff[7:4] == 4'(i)) begin
                    case (soff[3:0])
                        `SFR_SLOT_CFG0: begin
                            d.cfg[i].start_code = narrow(w[`SFR_C0_START_LSB +: 8], q.char8);
                            d.cfg[i].end_code = narrow(w[`SFR_C0_END_LSB +: 8], q.char8);
                            d.cfg[i].start_en = w[`SFR_C0_SEN_BIT];
                            d.cfg[i].end_en = w[`SFR_C0_EEN_BIT];
                            d.cfg[i].variable = w[`SFR_C0_VAR_BIT];
                            d.cfg[i].crc_en = w[`SFR_C0_CRC_BIT];
                        end
                        `SFR_SLOT_CFG1: begin
                            wcode = w[`SFR_C1_SKIP_LSB +: 8];
                            d.cfg[i].skip = (wcode > `SFR_SKIP_MAX) ? `SFR_SKIP_MAX : wcode;
                            d.cfg[i].len = w[`SFR_C1_LEN_LSB +: 8];
                        end
                        `SFR_SLOT_STAT: begin
                            if (w[`SFR_ST_CHKERR_BIT]) begin
                                d.slot[i].chk_err = 1'b0;
                            end
                        end
                        default: d.cfg[i] = d.cfg[i];
                    endcase
                end
            end
        end

        // inter-character timer, restarted by every byte
        to_ev = !q.to_fired && q.timeout != 8'h00 && q.idle_ticks >= q.timeout;
        if (rx_byte.valid) begin
            d.idle_ticks = 8'h00;
            d.to_fired = 1'b0;
        end else if (to_ev) begin
            d.to_fired = 1'b1;
        end else if (tick && q.idle_ticks < q.timeout) begin
            d.idle_ticks = q.idle_ticks + 8'h01;
        end

        // arbitration: an armed slot lacking a marker takes the stream alone
        any_open = 1'b0;
        win = 4'h0;
        for (int i = 0; i < SLOTS; i++) begin
            if (q.arm[i] && !(q.cfg[i].start_en && q.cfg[i].end_en)) begin
                any_open = 1'b1;
                win = 4'(i);
            end
        end
        for (int i = 0; i < SLOTS; i++) begin
            sel[i] = any_open ? (win == 4'(i)) : q.arm[i];
        end

        for (int i = 0; i < SLOTS; i++) begin
            fin = 1'b0;
            bad = 1'b0;
            ncnt = q.slot[i].cnt;
            nnew = q.slot[i].hist_new;
            nold = q.slot[i].hist_old;
            ncrc = q.slot[i].crc;
            if (!q.arm[i]) begin
                d.slot[i].phase = sfr_pkg::SP_IDLE;
            end else begin
                case (q.slot[i].phase)
                    sfr_pkg::SP_IDLE: begin
                        d.slot[i].cnt = q.cfg[i].skip;
                        d.slot[i].crc = `SFR_CRC_INIT;
                        if (q.cfg[i].skip != 8'h00) begin
                            d.slot[i].phase = sfr_pkg::SP_SKIP;
                        end else if (q.cfg[i].start_en) begin
                            d.slot[i].phase = sfr_pkg::SP_HUNT;
                        end else begin
                            d.slot[i].cnt = 8'h00;
                            d.slot[i].phase = sfr_pkg::SP_BODY;
                        end
                    end
                    sfr_pkg::SP_SKIP: begin
                        if (rx_byte.valid && sel[i]) begin
                            d.slot[i].cnt = q.slot[i].cnt - 8'h01;
                            if (q.slot[i].cnt == 8'h01) begin
                                d.slot[i].cnt = 8'h00;
                                d.slot[i].phase = q.cfg[i].start_en ? sfr_pkg::SP_HUNT
                                                                    : sfr_pkg::SP_BODY;
                            end
                        end
                    end
                    sfr_pkg::SP_HUNT: begin
                        // anything before the start marker is dropped without error
                        if (rx_byte.valid && sel[i] && bval == q.cfg[i].start_code) begin
                            d.slot[i].cnt = 8'h00;
                            d.slot[i].phase = sfr_pkg::SP_BODY;
                        end
                    end
                    sfr_pkg::SP_BODY: begin
                        if (rx_byte.valid && sel[i]) begin
                            if (q.cfg[i].end_en && bval == q.cfg[i].end_code) begin
                                fin = 1'b1;
                            end else begin
                                // crc lags two bytes so the check field stays out of it
                                if (q.slot[i].cnt >= 8'h02) begin
                                    ncrc = crc_upd(q.slot[i].crc, q.slot[i].hist_old);
                                end
                                nold = q.slot[i].hist_new;
                                nnew = bval;
                                ncnt = q.slot[i].cnt + 8'h01;
                                fin = ncnt == q.cfg[i].len;
                            end
                        end else if (to_ev && !q.cfg[i].end_en && q.cfg[i].variable
                                     && q.slot[i].cnt != 8'h00) begin
                            fin = 1'b1;
                        end
                        d.slot[i].cnt = ncnt;
                        d.slot[i].crc = ncrc;
                        d.slot[i].hist_new = nnew;
                        d.slot[i].hist_old = nold;
                        if (fin) begin
                            // received low byte first, the older of the two held bytes
                            bad = q.cfg[i].crc_en
                                  && (ncnt < 8'h02 || {nnew, nold} != ncrc);
                            d.slot[i].phase = sfr_pkg::SP_IDLE;
                            d.rx_done[i] = 1'b1;
                            if (bad) begin
                                d.rx_err[i] = 1'b1;
                                d.slot[i].chk_err = 1'b1;
                            end
                        end
                    end
                    default: d.slot[i].phase = sfr_pkg::SP_IDLE;
                endcase
            end
        end

        // transmit: edge-started, delayed in time units, then streamed
        d.tx_trig_prev = q.tx_trig;
        tx_rise = q.tx_trig && !q.tx_trig_prev;
        case (q.txst)
            sfr_pkg::TX_IDLE: begin
                if (tx_rise) begin
                    d.tx_cnt = 8'h00;
                    d.txst = sfr_pkg::TX_WAIT;
                end
            end
            sfr_pkg::TX_WAIT: begin
                // first unit may be short: the divider runs free
                if (q.tx_cnt >= q.tx_delay) begin
                    d.tx_idx = 2'b00;
                    d.tx_out.valid = 1'b1;
                    d.tx_out.data = q.tx_data[7:0];
                    d.txst = sfr_pkg::TX_SEND;
                end else if (tick) begin
                    d.tx_cnt = q.tx_cnt + 8'h01;
                end
            end
            sfr_pkg::TX_SEND: begin
                if (q.tx_out.valid && tx_ready) begin
                    if (q.tx_idx == q.tx_len) begin
                        d.tx_out.valid = 1'b0;
                        d.tx_out.data = 8'h00;
                        d.tx_done = 1'b1;
                        d.txst = sfr_pkg::TX_IDLE;
                    end else begin
                        d.tx_idx = q.tx_idx + 2'b01;
                        d.tx_out.data = q.tx_data[8 * (32'(q.tx_idx) + 1) +: 8];
                    end
                end
            end
            default: d.txst = sfr_pkg::TX_IDLE;
        endcase

        d.irq = |(pack_stat(d.rx_done, d.rx_err, d.tx_done) & d.mask);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q <= '0;
            q.char8 <= `SFR_RST_CHAR8;
        end else begin
            q <= d;
        end
    end

    assign apb_rsp = q.rsp;
    assign tx_byte = q.tx_out;
    assign irq = q.irq;
endmodule : sfr_top

// ==== src/sfr_regs.svh ====
// register offsets, field positions, reset values and timing constants
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

`define SFR_CLK_HZ 20000000
`define SFR_TICK_MS 100

`define SFR_ADDR_CFG 8'h00
`define SFR_ADDR_RXARM 8'h04
`define SFR_ADDR_TXCTRL 8'h08
`define SFR_ADDR_TXDATA 8'h0C
`define SFR_ADDR_ISTAT 8'h10
`define SFR_ADDR_IMASK 8'h14
`define SFR_SLOT_BASE 8'h20
`define SFR_SLOT_CFG0 4'h0
`define SFR_SLOT_CFG1 4'h4
`define SFR_SLOT_STAT 4'h8

`define SFR_CFG_CHAR8_BIT 0
`define SFR_CFG_TO_LSB 8
`define SFR_TX_TRIG_BIT 0
`define SFR_TX_DELAY_LSB 8
`define SFR_TX_LEN_LSB 16
`define SFR_TX_BUSY_BIT 31
`define SFR_C0_START_LSB 0
`define SFR_C0_END_LSB 8
`define SFR_C0_SEN_BIT 16
`define SFR_C0_EEN_BIT 17
`define SFR_C0_VAR_BIT 18
`define SFR_C0_CRC_BIT 19
`define SFR_C1_SKIP_LSB 0
`define SFR_C1_LEN_LSB 16
`define SFR_ST_CHKERR_BIT 0
`define SFR_IS_DONE_LSB 0
`define SFR_IS_ERR_LSB 8
`define SFR_IS_TX_BIT 16

`define SFR_RST_CHAR8 1'b1
`define SFR_SKIP_MAX 8'hF9
`define SFR_CRC_INIT 16'hFFFF
`define SFR_CRC_POLY 16'hA001

`endif

// ==== src/sfr_pkg.sv ====
// types shared by the frame parser files
package sfr_pkg;
    localparam int SFR_SLOTS = 4;

    typedef enum logic [1:0] {SP_IDLE, SP_SKIP, SP_HUNT, SP_BODY} sfr_phase_t;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} sfr_txst_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sfr_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sfr_apb_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sfr_byte_t;

    typedef struct packed {
        logic crc_en;
        logic variable;
        logic end_en;
        logic start_en;
        logic [7:0] end_code;
        logic [7:0] start_code;
        logic [7:0] skip;
        logic [7:0] len;
    } sfr_slot_cfg_t;

    typedef struct packed {
        sfr_phase_t phase;
        logic [7:0] cnt;
        logic [15:0] crc;
        logic [7:0] hist_new;
        logic [7:0] hist_old;
        logic chk_err;
    } sfr_slot_t;

    typedef struct packed {
        sfr_apb_rsp_t rsp;
        logic char8;
        logic [7:0] timeout;
        logic [SFR_SLOTS-1:0] arm;
        logic tx_trig;
        logic tx_trig_prev;
        logic [7:0] tx_delay;
        logic [1:0] tx_len;
        logic [31:0] tx_data;
        sfr_txst_t txst;
        logic [7:0] tx_cnt;
        logic [1:0] tx_idx;
        sfr_byte_t tx_out;
        logic [7:0] idle_ticks;
        logic to_fired;
        logic [SFR_SLOTS-1:0] rx_done;
        logic [SFR_SLOTS-1:0] rx_err;
        logic tx_done;
        logic [31:0] mask;
        sfr_slot_cfg_t [SFR_SLOTS-1:0] cfg;
        sfr_slot_t [SFR_SLOTS-1:0] slot;
        logic irq;
    } sfr_state_t;
endpackage : sfr_pkg

// ==== src/sfr_tick.sv ====
// divider giving a one-cycle pulse every 100 ms time unit
module sfr_tick #(
    parameter int unsigned CYCLES = 2000000
) (
    input wire logic mclk,
    input wire logic sys_rst,
    output logic tick
);
    localparam int W = $clog2(CYCLES);
    logic [W-1:0] cnt_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q == W'(CYCLES - 1)) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : sfr_tick

// ==== sim/sfr_top_props.sv ====
// checker for bus, interrupt and transmit handshake behaviour of the frame parser
`include "sfr_regs.svh"
module sfr_top_props (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire sfr_pkg::sfr_apb_req_t apb_req,
    input wire sfr_pkg::sfr_apb_rsp_t apb_rsp,
    input wire sfr_pkg::sfr_byte_t rx_byte,
    input wire sfr_pkg::sfr_byte_t tx_byte,
    input wire logic tx_ready,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // a full clear with no completing byte or transmit in flight must drop irq two edges on
    sequence s_clear_all;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == `SFR_ADDR_ISTAT
            && apb_req.pwdata == 32'hFFFF_FFFF && !rx_byte.valid && !tx_byte.valid;
    endsequence
    property p_rdy_setup;
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
    endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no pready after setup");
    property p_rdy_pulse;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_rdata_idle;
        !apb_rsp.pready |-> apb_rsp.prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
    property p_err_ready;
        apb_rsp.pslverr |-> apb_rsp.pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("slave error without pready");
    property p_rdy_access;
        apb_rsp.pready |-> apb_req.psel && apb_req.penable && $past(apb_req.psel);
    endproperty
    a_rdy_access: assert property (p_rdy_access) else $error("pready outside access");
    property p_tx_hold;
        tx_byte.valid && !tx_ready |=> tx_byte.valid && $stable(tx_byte.data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit byte dropped early");
    property p_rst_quiet;
        $past(sys_rst) |-> !irq && !tx_byte.valid && !apb_rsp.pready;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    property p_irq_clear;
        s_clear_all |-> ##2 !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq stays after clear");
    c_slverr: cover property (apb_rsp.pslverr);
    c_tx_take: cover property (tx_byte.valid && tx_ready);
    c_irq_up: cover property ($rose(irq));
endmodule : sfr_top_props

bind sfr_top sfr_top_props u_props (.mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .rx_byte(rx_byte), .tx_byte(tx_byte), .tx_ready(tx_ready), .irq(irq));

// ==== sim/sfr_far.sv ====
// far-side serial device: sends characters and takes transmitted ones with random stalls
module sfr_far (
    input wire logic mclk,
    output sfr_pkg::sfr_byte_t rx_byte,
    input wire sfr_pkg::sfr_byte_t tx_byte,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    initial begin
        rx_byte = '0;
    end
    always @(posedge mclk) begin
        if (tx_byte.valid && tx_ready) got.push_back(tx_byte.data);
        tx_ready <= 1'($urandom % 2);
    end
    task automatic send(input logic [7:0] d);
        @(posedge mclk);
        rx_byte <= '{valid: 1'b1, data: d};
        @(posedge mclk);
        // inverted data so a stale value is never mistaken for a character
        rx_byte <= '{valid: 1'b0, data: ~d};
        repeat (2) @(posedge mclk);
    endtask : send
endmodule : sfr_far

// ==== sim/sfr_top_tb.sv ====
// self-checking bench for the frame parser with its own status and traffic model
`include "sfr_regs.svh"
module sfr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ist = `SFR_ADDR_ISTAT;
    localparam logic [7:0] arm = `SFR_ADDR_RXARM;
    logic mclk;
    logic sys_rst;
    logic tx_ready;
    logic irq;
    logic rerr;
    logic [31:0] rdat;
    logic [31:0] r;
    logic [15:0] c;
    logic [7:0] b[$];
    int fails;
    int tests_run;
    int n;
    sfr_pkg::sfr_apb_req_t req;
    sfr_pkg::sfr_apb_rsp_t rsp;
    sfr_pkg::sfr_byte_t rx;
    sfr_pkg::sfr_byte_t tx;
    sfr_top #(.TICK_CYCLES(20)) dut (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req),
        .apb_rsp(rsp), .rx_byte(rx), .tx_byte(tx), .tx_ready(tx_ready), .irq(irq));
    sfr_far far (.mclk(mclk), .rx_byte(rx), .tx_byte(tx), .tx_ready(tx_ready));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // no latency is assumed; a missing pready is cut off after 16 cycles
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 16);
        chk({31'h0, rsp.pready}, 32'h1);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req <= '0;
        @(posedge mclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rd
    task automatic send_all();
        foreach (b[i]) far.send(b[i]);
    endtask : send_all
    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_is
    function automatic logic [15:0] crc16();
        logic [15:0] v;
        v = 16'hFFFF;
        foreach (b[i]) begin
            v ^= {8'h00, b[i]};
            repeat (8) v = v[0] ? (v >> 1) ^ 16'hA001 : v >> 1;
        end
        return v;
    endfunction : crc16
    initial begin
        req = '0;
        sys_rst = 1'b1;
        fails = 0;
        tests_run = 0;
        void'($urandom(92370));
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(8'hFC, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        rd(`SFR_ADDR_CFG, 32'h1);
        $display("test bus done");
        apb(1'b1, 8'h20, 32'h0003_0D02);
        apb(1'b1, 8'h34, 32'h0002_0002);
        apb(1'b1, arm, 32'h3);
        b = '{8'h02, 8'h41, 8'h42};
        send_all();
        rd(ist, 32'h0);
        far.send(8'h0D);
        rd(ist, 32'h2);
        $display("test arbitration done");
        apb(1'b1, ist, 32'hFFFF_FFFF);
        apb(1'b1, arm, 32'h1);
        apb(1'b1, `SFR_ADDR_IMASK, 32'h1);
        b = '{8'h55, 8'h0D};
        send_all();
        rd(ist, 32'h0);
        b = '{8'h02, 8'h41, 8'h0D};
        send_all();
        rd(ist, 32'h1);
        rd(8'h28, 32'h0);
        irq_is(1'b1);
        apb(1'b1, `SFR_ADDR_IMASK, 32'h0);
        irq_is(1'b0);
        apb(1'b1, `SFR_ADDR_IMASK, 32'h1);
        irq_is(1'b1);
        apb(1'b1, ist, 32'hFFFF_FFFF);
        irq_is(1'b0);
        $display("test markers done");
        apb(1'b1, 8'h40, 32'h000B_0D02);
        apb(1'b1, arm, 32'h4);
        for (int t = 0; t < 2; t++) begin
            do begin
                b = {};
                repeat (4) b.push_back(8'h40 + 8'($urandom % 64));
                c = crc16();
            end while (c[7:0] inside {8'h0D, 8'h8D} || c[15:8] == 8'h0D);
            b.push_back(c[7:0] ^ {t[0], 7'h0});
            b.push_back(c[15:8]);
            b.push_front(8'h02);
            b.push_back(8'h0D);
            send_all();
            apb(1'b0, ist, 32'h0);
            chk(rdat & (t ? 32'h400 : 32'h404), t ? 32'h400 : 32'h4);
            rd(8'h48, {31'h0, t[0]});
            apb(1'b1, ist, 32'hFFFF_FFFF);
            apb(1'b1, 8'h48, 32'h1);
        end
        $display("test check field done");
        apb(1'b1, `SFR_ADDR_CFG, 32'h0000_0201);
        apb(1'b1, 8'h50, 32'h0004_0000);
        apb(1'b1, arm, 32'h8);
        b = '{8'h31, 8'h32, 8'h33};
        send_all();
        rd(ist, 32'h0);
        repeat (80) @(posedge mclk);
        rd(ist, 32'h8);
        apb(1'b1, ist, 32'hFFFF_FFFF);
        apb(1'b1, arm, 32'h0);
        b = '{8'h02, 8'h41, 8'h0D};
        send_all();
        rd(ist, 32'h0);
        $display("test timeout done");
        apb(1'b1, 8'h24, 32'h0003_0000);
        apb(1'b1, arm, 32'h5);
        b = '{8'h02, 8'h41, 8'h42, 8'h43};
        send_all();
        rd(ist, 32'h1);
        far.send(8'h0D);
        b = '{8'h41};
        c = crc16();
        rd(ist, {21'h0, c != 16'h4342, 7'h0, 3'h5});
        apb(1'b1, ist, 32'hFFFF_FFFF);
        $display("test max length done");
        r = $urandom;
        apb(1'b1, `SFR_ADDR_TXDATA, r);
        apb(1'b1, `SFR_ADDR_IMASK, 32'h0001_0000);
        apb(1'b1, `SFR_ADDR_TXCTRL, 32'h0003_0201);
        n = 0;
        while (tx.valid !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, n >= 18 && n <= 45}, 32'h1);
        while (far.got.size() < 4 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        for (int i = 0; i < 4; i++) chk({24'h0, far.got[i]}, {24'h0, r[8*i+:8]});
        irq_is(1'b1);
        rd(ist, 32'h0001_0000);
        apb(1'b1, `SFR_ADDR_TXCTRL, 32'h0000_0001);
        repeat (100) @(posedge mclk);
        chk(far.got.size(), 4);
        $display("test transmit done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("mismatch at %0t: run did not finish", $time);
        summarize();
    end
endmodule : sfr_top_tb
